// file: pkg/pcu_consts.svh
// Purpose: register map, field positions and reset values of the parallel capture unit
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   definitions only
`ifndef PCU_CONSTS_SVH
`define PCU_CONSTS_SVH

// ==========================================
// register byte offsets
`define PCU_OFS_CONFIG       6'h00
`define PCU_OFS_CONTROL      6'h04
`define PCU_OFS_IRQ_EN_SET   6'h08
`define PCU_OFS_IRQ_EN_CLR   6'h0c
`define PCU_OFS_IRQ_MASK     6'h10
`define PCU_OFS_STATUS       6'h14
`define PCU_OFS_STATUS_CLR   6'h18
`define PCU_OFS_DATA         6'h1c
`define PCU_OFS_REVISION     6'h20

// ==========================================
// configuration fields
`define PCU_CFG_ODD          7
`define PCU_CFG_HALF         6
`define PCU_CFG_EDGE         5
`define PCU_CFG_EVENT        4
`define PCU_CFG_QUAL_HI      3
`define PCU_CFG_QUAL_LO      2
`define PCU_CFG_SIZE_HI      1
`define PCU_CFG_SIZE_LO      0
`define PCU_CFG_WMASK        32'h0000_00ff

// ==========================================
// control action bits
`define PCU_CTL_ON           0
`define PCU_CTL_OFF          1
`define PCU_CTL_START        2
`define PCU_CTL_STOP         3

// ==========================================
// status and interrupt bits
`define PCU_ST_EN            0
`define PCU_ST_CS            1
`define PCU_ST_READY         2
`define PCU_ST_OVERFLOW      3

// ==========================================
// reset values and identity (arbitrary values)
`define PCU_RST_CONFIG       8'h00
`define PCU_REV_VERSION      12'h0a5
`define PCU_REV_VARIANT      4'h0

// ==========================================
// axi answers
`define PCU_RESP_OKAY        2'b00
`define PCU_RESP_SLVERR      2'b10

`endif

// file: pkg/pcu_pkg.sv
// Purpose: types of the parallel capture unit
// Assumes: nothing
// Notes:   constants live in pcu_consts.svh
package pcu_pkg;

	// ==========================================
	// qualifier modes
	typedef enum logic [1:0] {
		PCU_QUAL_A,
		PCU_QUAL_AND,
		PCU_QUAL_OR,
		PCU_QUAL_ALWAYS
	} pcu_qual_type;

	// ==========================================
	// word widths
	typedef enum logic [1:0] {
		PCU_SIZE_8,
		PCU_SIZE_16,
		PCU_SIZE_32A,
		PCU_SIZE_32B
	} pcu_size_type;

	// ==========================================
	// bus slave states
	typedef enum logic [1:0] {
		PCU_W_IDLE,
		PCU_W_RESP
	} pcu_wstate_type;

endpackage

// file: src/pcu_capture.sv
// Purpose: parallel capture unit: 8-bit sampled bus, registers over AXI4-Lite
// Assumes: core_clk at least twice the sample clock; inputs are asynchronous
// Notes:   single design file; no interrupt block, one request level only
`include "pcu_consts.svh"

module pcu_capture
	import pcu_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// axi4-lite write address
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// sample pins
	input  wire logic        sample_clock_in,
	input  wire logic [7:0]  sample_bus_in,
	input  wire logic        qualifier_in_a,
	input  wire logic        qualifier_in_b,
	// peripheral events, one-cycle pulses on core_clk
	input  wire logic        event_start,
	input  wire logic        event_stop,
	// dma and interrupt
	output logic             dma_request,
	input  wire logic        dma_ack,
	output logic             irq
);

	// ==========================================
	// helpers
	function automatic logic [3:0] size_bytes(input logic [1:0] sz);
		case (pcu_size_type'(sz))
			PCU_SIZE_8:  size_bytes = 4'h1;
			PCU_SIZE_16: size_bytes = 4'h2;
			default:     size_bytes = 4'h4;
		endcase
	endfunction

	function automatic logic qual_ok(input logic [1:0] m, input logic a, input logic b);
		case (pcu_qual_type'(m))
			PCU_QUAL_A:   qual_ok = a;
			PCU_QUAL_AND: qual_ok = a & b;
			PCU_QUAL_OR:  qual_ok = a | b;
			default:      qual_ok = 1'b1;
		endcase
	endfunction

	// ==========================================
	// registers
	logic [7:0]  config_q;
	logic        unit_on_q;
	logic        capturing_q;
	logic [1:0]  irq_mask_q;
	logic        ready_flag_q;
	logic        overflow_flag_q;
	logic [31:0] captured_bytes_q;
	logic [31:0] buf_q;
	logic [2:0]  fill_q;
	logic        index_odd_q;
	logic        unread_q;

	// ==========================================
	// pin synchronisers, two flops each
	logic [10:0] sync1_q;
	logic [10:0] sync2_q;
	logic        clk_prev_q;

	always_ff @(posedge core_clk) begin
		sync1_q <= {sample_clock_in, qualifier_in_b, qualifier_in_a, sample_bus_in};
		sync2_q <= sync1_q;
		clk_prev_q <= sync2_q[10];
	end

	// data and qualifiers go through the same delay as the clock, so they stay aligned
	logic edge_seen;
	logic take_byte;
	logic keep_byte;
	always_comb begin
		if (config_q[`PCU_CFG_EDGE])
			edge_seen = clk_prev_q & ~sync2_q[10];
		else
			edge_seen = ~clk_prev_q & sync2_q[10];
		take_byte = edge_seen & unit_on_q & capturing_q
			& qual_ok(config_q[`PCU_CFG_QUAL_HI:`PCU_CFG_QUAL_LO], sync2_q[8], sync2_q[9]);
		keep_byte = ~config_q[`PCU_CFG_HALF]
			| (index_odd_q == config_q[`PCU_CFG_ODD]);
	end

	// ==========================================
	// axi4-lite write path: takes address and data in either order
	logic           aw_held_q;
	logic [5:0]     aw_addr_q;
	logic           w_held_q;
	logic [31:0]    w_data_q;
	logic [3:0]     w_strb_q;
	pcu_wstate_type wstate_q;
	logic           wr_fire;
	logic [31:0]    wr_bits;

	always_comb begin
		wr_fire = aw_held_q & w_held_q & (wstate_q == PCU_W_IDLE);
		// partial strobes: only lanes written count as ones; the config write takes w_data_q unmasked
		wr_bits = w_data_q & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
			{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_addr_q     <= 6'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PCU_RESP_OKAY;
			wstate_q      <= PCU_W_IDLE;
		end else begin
			s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			case (wstate_q)
				PCU_W_IDLE: begin
					if (wr_fire) begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= (aw_addr_q > `PCU_OFS_REVISION || aw_addr_q[1:0] != 2'b00)
							? `PCU_RESP_SLVERR : `PCU_RESP_OKAY;
						wstate_q     <= PCU_W_RESP;
					end
				end
				PCU_W_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_held_q    <= 1'b0;
						w_held_q     <= 1'b0;
						wstate_q     <= PCU_W_IDLE;
					end
				end
				default: wstate_q <= PCU_W_IDLE;
			endcase
		end
	end

	logic wr_cfg, wr_ctl, wr_mset, wr_mclr, wr_sclr;
	always_comb begin
		wr_cfg  = wr_fire & (aw_addr_q == `PCU_OFS_CONFIG);
		wr_ctl  = wr_fire & (aw_addr_q == `PCU_OFS_CONTROL);
		wr_mset = wr_fire & (aw_addr_q == `PCU_OFS_IRQ_EN_SET);
		wr_mclr = wr_fire & (aw_addr_q == `PCU_OFS_IRQ_EN_CLR);
		wr_sclr = wr_fire & (aw_addr_q == `PCU_OFS_STATUS_CLR);
	end

	// ==========================================
	// axi4-lite read path
	logic rd_data_hit;
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`PCU_OFS_CONFIG:    rd_word = {24'h00_0000, config_q};
			`PCU_OFS_CONTROL:   rd_word = 32'h0000_0000;
			`PCU_OFS_IRQ_MASK:  rd_word = {28'h000_0000, irq_mask_q, 2'b00};
			`PCU_OFS_STATUS:    rd_word = {28'h000_0000, overflow_flag_q, ready_flag_q,
				capturing_q, unit_on_q};
			`PCU_OFS_DATA:      rd_word = captured_bytes_q;
			`PCU_OFS_REVISION:  rd_word = {12'h000, `PCU_REV_VARIANT, 4'h0,
				`PCU_REV_VERSION};
			default:            rd_word = 32'h0000_0000;
		endcase
		rd_data_hit = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `PCU_OFS_DATA);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PCU_RESP_OKAY;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= (s_axi_araddr > `PCU_OFS_REVISION || s_axi_araddr[1:0] != 2'b00)
					? `PCU_RESP_SLVERR : `PCU_RESP_OKAY;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready)
					s_axi_rvalid <= 1'b0;
			end else begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================
	// configuration; kept simple, writes while on are the user's hazard
	always_ff @(posedge core_clk) begin
		if (srst)
			config_q <= `PCU_RST_CONFIG;
		else if (wr_cfg)
			config_q <= w_data_q[7:0];
	end

	// ==========================================
	// control: on/off and capture start/stop
	logic stop_now;
	always_comb begin
		stop_now = capturing_q & ((wr_ctl & wr_bits[`PCU_CTL_STOP])
			| (config_q[`PCU_CFG_EVENT] & event_stop)
			| (wr_ctl & wr_bits[`PCU_CTL_OFF]));
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			unit_on_q   <= 1'b0;
			capturing_q <= 1'b0;
		end else begin
			if (wr_ctl & wr_bits[`PCU_CTL_ON])
				unit_on_q <= 1'b1;
			else if (wr_ctl & wr_bits[`PCU_CTL_OFF])
				unit_on_q <= 1'b0;
			if (stop_now)
				capturing_q <= 1'b0;
			else if ((wr_ctl & wr_bits[`PCU_CTL_START])
				| (config_q[`PCU_CFG_EVENT] & event_start))
				capturing_q <= 1'b1;
		end
	end

	// ==========================================
	// byte index and word assembly
	logic       word_full;
	logic       flush;
	logic [2:0] fill_inc;
	logic [31:0] buf_next;
	always_comb begin
		fill_inc = fill_q + 3'd1;
		buf_next = buf_q;
		buf_next[fill_q[1:0]*8 +: 8] = sync2_q[7:0];
		word_full = take_byte & keep_byte
			& ({1'b0, fill_inc} == size_bytes(config_q[`PCU_CFG_SIZE_HI:`PCU_CFG_SIZE_LO]));
		// a byte taken in the stop cycle joins the partial word before the flush
		flush = stop_now & ~word_full
			& ((fill_q != 3'd0) | (take_byte & keep_byte));
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			index_odd_q <= 1'b0;
			fill_q      <= 3'd0;
			buf_q       <= 32'h0000_0000;
		end else begin
			if (take_byte)
				index_odd_q <= ~index_odd_q;
			if (word_full | flush) begin
				fill_q <= 3'd0;
				buf_q  <= 32'h0000_0000;
			end else if (take_byte & keep_byte) begin
				fill_q <= fill_inc;
				buf_q  <= buf_next;
			end
		end
	end

	// ==========================================
	// data register, flags, dma and request
	logic word_done;
	logic byte_kept;
	always_comb begin
		word_done = word_full | flush;
		byte_kept = take_byte & keep_byte;
	end

	// data register; a flush carries the byte of its own cycle too
	always_ff @(posedge core_clk) begin
		if (srst)
			captured_bytes_q <= 32'h0000_0000;
		else if (word_done)
			captured_bytes_q <= byte_kept ? buf_next : buf_q;
	end

	// a word landing in the read cycle counts as new and unread
	always_ff @(posedge core_clk) begin
		if (srst)
			unread_q <= 1'b0;
		else if (word_done)
			unread_q <= 1'b1;
		else if (rd_data_hit | (dma_request & dma_ack))
			unread_q <= 1'b0;
	end

	// flags: set wins over clear, so no event is lost to a late clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ready_flag_q    <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else begin
			if (word_done)
				ready_flag_q <= 1'b1;
			else if (wr_sclr & wr_bits[`PCU_ST_READY])
				ready_flag_q <= 1'b0;
			if (byte_kept & unread_q)
				overflow_flag_q <= 1'b1;
			else if (wr_sclr & wr_bits[`PCU_ST_OVERFLOW])
				overflow_flag_q <= 1'b0;
		end
	end

	// dma request: an ack or a data read serves it
	always_ff @(posedge core_clk) begin
		if (srst)
			dma_request <= 1'b0;
		else if (word_done)
			dma_request <= 1'b1;
		else if (dma_ack | rd_data_hit)
			dma_request <= 1'b0;
	end

	// mask and request level; irq lags the flags by one cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_mask_q <= 2'b00;
			irq        <= 1'b0;
		end else begin
			irq_mask_q <= (irq_mask_q
				| ({2{wr_mset}} & wr_bits[`PCU_ST_OVERFLOW:`PCU_ST_READY]))
				& ~({2{wr_mclr}} & wr_bits[`PCU_ST_OVERFLOW:`PCU_ST_READY]);
			irq <= |({overflow_flag_q, ready_flag_q} & irq_mask_q);
		end
	end

endmodule

// file: verif/pcu_sensor_model.sv
// Purpose: byte source on the far side of the capture pins
// Assumes: go rises after n_edges has settled
// Notes:   byte i is 8'h30 + i, with a clock edge in mid-byte
module pcu_sensor_model (
	// control from the bench
	input  wire logic       go,
	input  wire logic [4:0] n_edges,
	// pins
	output logic            sample_clock_in,
	output logic [7:0]      sample_bus_in,
	output logic            qualifier_in_a,
	output logic            qualifier_in_b,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// one byte per half period, 125 ns clock
	// one process drives every pin, so each has a single driver
	initial begin
		sample_clock_in = 1'b0;
		sample_bus_in = 8'h00;
		qualifier_in_a = 1'b0;
		qualifier_in_b = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge go);
			busy = 1'b1;
			for (int i = 0; i < int'(n_edges); i++) begin
				sample_bus_in = 8'h30 + 8'(i);
				qualifier_in_a = i[1];
				qualifier_in_b = i[2];
				#31;
				sample_clock_in = ~sample_clock_in;
				#31.5;
			end
			// released bus must not look like the last byte
			sample_bus_in = ~sample_bus_in;
			busy = 1'b0;
		end
	end
endmodule

// file: verif/pcu_capture_asserts.sv
// Purpose: port checks of the capture unit
// Assumes: one clock domain, srst synchronous
// Notes:   bound to every pcu_capture
`include "pcu_consts.svh"
module pcu_capture_asserts (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        srst,
	// register bus
	input wire logic [5:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [5:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	// dma and interrupt
	input wire logic        dma_request,
	input wire logic        dma_ack,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic wr_hs;
	logic rd_hs;
	assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rd_hs = s_axi_arvalid && s_axi_arready;
	// ==========================================
	// interrupt line
	a_clear_drops_irq: assert property (
		wr_hs && s_axi_awaddr == `PCU_OFS_STATUS_CLR && s_axi_wdata[3:2] == 2'b11
		|-> ##[1:4] !irq) else $error("irq stays after full status clear");
	a_unmask_drops_irq: assert property (
		wr_hs && s_axi_awaddr == `PCU_OFS_IRQ_EN_CLR && s_axi_wdata[3:2] == 2'b11
		|-> ##[1:4] !irq) else $error("irq stays with both masks off");
	a_irq_holds: assert property (
		irq && !s_axi_wvalid && !s_axi_bvalid |=> irq)
		else $error("irq dropped without a write");
	// ==========================================
	// dma request
	a_dma_holds: assert property (
		dma_request && !dma_ack && !s_axi_arvalid && !s_axi_rvalid |=> dma_request)
		else $error("dma request dropped unserved");
	// ==========================================
	// read values
	a_ctrl_reads_zero: assert property (
		rd_hs && s_axi_araddr == `PCU_OFS_CONTROL |=> s_axi_rvalid && s_axi_rdata == 32'h0)
		else $error("control read not zero");
	a_rev_value: assert property (
		rd_hs && s_axi_araddr == `PCU_OFS_REVISION |=> s_axi_rvalid
		&& s_axi_rdata == {12'h000, `PCU_REV_VARIANT, 4'h0, `PCU_REV_VERSION})
		else $error("revision value wrong");
	a_status_shape: assert property (
		rd_hs && s_axi_araddr == `PCU_OFS_STATUS |=> s_axi_rdata[31:4] == 28'h0
		&& (!s_axi_rdata[1] || s_axi_rdata[0])) else $error("status bits wrong");
	a_mask_shape: assert property (
		rd_hs && s_axi_araddr == `PCU_OFS_IRQ_MASK |=> s_axi_rdata[31:4] == 28'h0
		&& s_axi_rdata[1:0] == 2'b00) else $error("mask has stray bits");
	a_unmapped_err: assert property (
		rd_hs && s_axi_araddr > 6'h20 |=> s_axi_rresp == `PCU_RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule
bind pcu_capture pcu_capture_asserts pcu_capture_asserts_inst (.core_clk, .srst,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .dma_request, .dma_ack, .irq);

// file: verif/pcu_capture_tb.sv
// Purpose: register-level tests of the capture unit
// Assumes: partner model makes the sample clock
// Notes:   expected words built from the model's byte pattern
`include "pcu_consts.svh"
module pcu_capture_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk = 1'b0, srst = 1'b1, go = 1'b0, dma_ack = 1'b0;
	logic        event_start = 1'b0, event_stop = 1'b0;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        sample_clock_in, qualifier_in_a, qualifier_in_b, dma_request, irq, busy;
	logic [7:0]  sample_bus_in;
	logic [4:0]  n_edges = 5'h00;
	int          fail_count = 0, cmp_count = 0;
	// ==========================================
	// scenario table: config, edges, expected word
	localparam logic [7:0] CFG [7] = '{8'h0e, 8'h2f, 8'h02, 8'h0a, 8'h05, 8'h4e, 8'hce};
	localparam logic [4:0] NE [7] = '{5'h08, 5'h08, 5'h10, 5'h0c, 5'h10, 5'h10, 5'h10};
	localparam logic [31:0] EXP [7] = '{32'h36343230, 32'h37353331, 32'h3e3a3632,
		32'h3a363432, 32'h00003e36, 32'h3c383430, 32'h3e3a3632};
	always #4 core_clk = ~core_clk;
	pcu_capture pcu_capture_inst (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sample_clock_in, .sample_bus_in, .qualifier_in_a, .qualifier_in_b,
		.event_start, .event_stop, .dma_request, .dma_ack, .irq);
	pcu_sensor_model pcu_sensor_model_inst (.go, .n_edges, .sample_clock_in,
		.sample_bus_in, .qualifier_in_a, .qualifier_in_b, .busy);
	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_val = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [5:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_val, exp);
	endtask
	task automatic burst(input logic [4:0] n);
		@(posedge core_clk) n_edges <= n;
		@(posedge core_clk) go <= 1'b1;
		@(posedge core_clk) go <= 1'b0;
		while (busy) @(posedge core_clk);
		// pin-to-flag latency is three cycles
		repeat (8) @(posedge core_clk);
	endtask
	task automatic ev(input logic s, input logic p);
		@(posedge core_clk);
		event_start <= s;
		event_stop <= p;
		@(posedge core_clk);
		event_start <= 1'b0;
		event_stop <= 1'b0;
	endtask
	task automatic summarize();
		if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================
	// watchdog, about twenty times the expected run
	initial begin
		#200us;
		fail_count++;
		summarize();
	end
	// ==========================================
	// tests
	initial begin
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		repeat (2) @(posedge core_clk);
		rc(`PCU_OFS_CONFIG, 32'h0);
		rc(`PCU_OFS_STATUS, 32'h0);
		rc(`PCU_OFS_DATA, 32'h0);
		rc(`PCU_OFS_REVISION, {12'h000, `PCU_REV_VARIANT, 4'h0, `PCU_REV_VERSION});
		rd(6'h24);
		chk({30'h0, resp}, {30'h0, `PCU_RESP_SLVERR});
		wr(6'h28, 32'h0);
		chk({30'h0, resp}, {30'h0, `PCU_RESP_SLVERR});
		rc(`PCU_OFS_IRQ_MASK, 32'h0);
		wr(`PCU_OFS_IRQ_EN_SET, 32'h0000000c);
		rc(`PCU_OFS_IRQ_MASK, 32'h0000000c);
		for (int i = 0; i < 7; i++) begin
			wr(`PCU_OFS_CONFIG, {24'h0, CFG[i]});
			rc(`PCU_OFS_CONFIG, {24'h0, CFG[i]});
			wr(`PCU_OFS_CONTROL, 32'h5);
			rc(`PCU_OFS_STATUS, 32'h3);
			burst(NE[i]);
			rc(`PCU_OFS_STATUS, 32'h7);
			chk({31'h0, irq}, 32'h1);
			chk({31'h0, dma_request}, 32'h1);
			rd(`PCU_OFS_DATA);
			chk(rd_val & ((CFG[i][1:0] == 2'b01) ? 32'hffff : 32'hffffffff), EXP[i]);
			wr(`PCU_OFS_STATUS_CLR, 32'hc);
			repeat (2) @(posedge core_clk);
			chk({31'h0, irq}, 32'h0);
			chk({31'h0, dma_request}, 32'h0);
			wr(`PCU_OFS_CONTROL, 32'h2);
			rc(`PCU_OFS_STATUS, 32'h0);
			rc(`PCU_OFS_CONTROL, 32'h0);
		end
		// overrun with the ready source masked
		wr(`PCU_OFS_IRQ_EN_CLR, 32'h4);
		rc(`PCU_OFS_IRQ_MASK, 32'h8);
		wr(`PCU_OFS_CONFIG, 32'h0c);
		wr(`PCU_OFS_CONTROL, 32'h5);
		burst(5'h04);
		rc(`PCU_OFS_STATUS, 32'hf);
		chk({31'h0, irq}, 32'h1);
		rc(`PCU_OFS_STATUS, 32'hf);
		wr(`PCU_OFS_STATUS_CLR, 32'h8);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		rc(`PCU_OFS_STATUS, 32'h7);
		// read the word so the next scenario starts with nothing unread
		rd(`PCU_OFS_DATA);
		chk(rd_val & 32'hffffff00, 32'h0);
		wr(`PCU_OFS_STATUS_CLR, 32'hc);
		wr(`PCU_OFS_CONTROL, 32'h2);
		// stop with half a word buffered
		wr(`PCU_OFS_CONFIG, 32'h0e);
		wr(`PCU_OFS_CONTROL, 32'h5);
		burst(5'h04);
		rc(`PCU_OFS_STATUS, 32'h3);
		wr(`PCU_OFS_CONTROL, 32'h8);
		rc(`PCU_OFS_STATUS, 32'h5);
		chk({31'h0, dma_request}, 32'h1);
		@(posedge core_clk) dma_ack <= 1'b1;
		@(posedge core_clk) dma_ack <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({31'h0, dma_request}, 32'h0);
		rd(`PCU_OFS_DATA);
		chk(rd_val & 32'hffff, 32'h3230);
		// events, first ignored, then obeyed
		wr(`PCU_OFS_CONTROL, 32'h2);
		wr(`PCU_OFS_STATUS_CLR, 32'hc);
		wr(`PCU_OFS_CONTROL, 32'h1);
		ev(1'b1, 1'b0);
		rc(`PCU_OFS_STATUS, 32'h1);
		wr(`PCU_OFS_CONTROL, 32'h2);
		wr(`PCU_OFS_CONFIG, 32'h1e);
		wr(`PCU_OFS_CONTROL, 32'h1);
		ev(1'b1, 1'b0);
		rc(`PCU_OFS_STATUS, 32'h3);
		ev(1'b0, 1'b1);
		rc(`PCU_OFS_STATUS, 32'h1);
		wr(`PCU_OFS_IRQ_EN_CLR, 32'hc);
		rc(`PCU_OFS_IRQ_MASK, 32'h0);
		summarize();
	end
endmodule
